/* File: logic/rst_regs.sv */
// Radio status word and trim register bank with serial register port
`timescale 1ns/1ns

module rst_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire rst_pkg::rst_sel_t sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    // Control register one bits
    input wire logic extended_feature_enable_i,
    input wire logic offset_measure_select_i,
    input wire logic slicer_ref_internal_i,
    // Radio measurement sources
    input wire logic synth_lock_flag_i,
    input wire logic [5:0] measured_signal_level_i,
    input wire logic [5:0] supply_adc_i,
    input wire logic [5:0] disc_adc_i,
    input wire logic alert_pin_raw_i,
    input wire logic test_msg_mode_i,
    input wire logic alert_msg_error_i,
    input wire logic [4:0] alert_payload_length_i,
    input wire logic [9:0] alert_bit_period_i,
    // Analog trim controls
    output logic [3:0] slicer_reference_trim_o,
    output logic discriminator_shift_up_o,
    output logic discriminator_shift_down_o,
    output logic [31:0] trim_ext_o
);
    import rst_pkg::*;

    // ==================================================
    // Trim storage
    rst_trim_if tif ();

    assign tif.wr_en = wr_i && (sel_i == RST_SEL_TRIM);
    assign tif.wr_data = wdata_i;
    assign tif.ext_en = extended_feature_enable_i;

    rst_trim_reg u_trim (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .bus(tif)
    );

    // ==================================================
    // Status capture
    logic [30:0] stat_r;
    logic [30:0] stat_nxt;

    // Assemble the live status word
    always_comb begin
        stat_nxt = '0;
        stat_nxt[ST_LOCK_B] = synth_lock_flag_i;
        stat_nxt[ST_SIG_HI:ST_SIG_LO] = measured_signal_level_i;
        stat_nxt[ST_SUP_HI:ST_SUP_LO] = offset_measure_select_i ? disc_adc_i
                                                                : supply_adc_i;
        stat_nxt[ST_ALERT_B] = alert_pin_raw_i;
        stat_nxt[ST_RSVD_B] = 1'b0;
        stat_nxt[ST_ERR_B] = test_msg_mode_i & alert_msg_error_i;
        stat_nxt[ST_LEN_HI:ST_LEN_LO] = alert_payload_length_i;
        stat_nxt[ST_PER_HI:ST_PER_LO] = alert_bit_period_i;
    end

    // Status follows the sources only; the port cannot write it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // ==================================================
    // Read port and trim outputs
    logic [31:0] rdata_nxt;
    logic rvalid_nxt;
    logic [31:0] view_trim;

    // Read mux with view masking
    always_comb begin
        view_trim = extended_feature_enable_i ? (tif.trim & TRIM_EXT_MASK)
                                              : (tif.trim & TRIM_LEG_MASK);
        rvalid_nxt = rd_i;
        rdata_nxt = '0;
        if (rd_i) begin
            unique case (sel_i)
                RST_SEL_STATUS: rdata_nxt = {1'b0, stat_r};
                RST_SEL_TRIM: rdata_nxt = view_trim;
                default: rdata_nxt = '0;
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
            rvalid_o <= 1'b0;
            slicer_reference_trim_o <= TRIM_LEG_RST[TR_SLICE_HI:TR_SLICE_LO];
            discriminator_shift_up_o <= 1'b0;
            discriminator_shift_down_o <= 1'b0;
            trim_ext_o <= '0;
        end else begin
            rdata_o <= rdata_nxt;
            rvalid_o <= rvalid_nxt;
            slicer_reference_trim_o <= tif.trim[TR_SLICE_HI:TR_SLICE_LO];
            discriminator_shift_up_o <= tif.trim[TR_UP_B];
            discriminator_shift_down_o <= tif.trim[TR_DN_B];
            trim_ext_o <= view_trim;
        end
    end
endmodule

/* File: logic/rst_trim_reg.sv */
// Trim register storage with legacy and extended views
`timescale 1ns/1ns
module rst_trim_reg (
    input wire logic clk_i,
    input wire logic rst_i,
    rst_trim_if.owner bus
);
    import rst_pkg::*;

    logic [31:0] trim_r;
    logic [31:0] trim_nxt;

    // Next value: legacy write touches bits 5:0 only, extended write all defined bits
    always_comb begin
        trim_nxt = trim_r;
        if (bus.wr_en) begin
            if (bus.ext_en) begin
                trim_nxt = bus.wr_data & TRIM_EXT_MASK;
            end else begin
                trim_nxt = (trim_r & ~TRIM_LEG_MASK) | (bus.wr_data & TRIM_LEG_MASK);
            end
        end
    end

    // Storage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trim_r <= TRIM_EXT_RST;
        end else begin
            trim_r <= trim_nxt;
        end
    end

    assign bus.trim = trim_r;
endmodule

/* File: pkg/rst_pkg.sv */
// Package with field layouts, reset values and widths for the status and trim registers
package rst_pkg;
    // ==================================================
    // Widths
    localparam int STAT_W = 31;
    localparam int TRIM_W = 32;
    localparam int LEG_W = 6;
    // ==================================================
    // Status field positions
    localparam int ST_LOCK_B = 30;
    localparam int ST_SIG_HI = 29;
    localparam int ST_SIG_LO = 24;
    localparam int ST_SUP_HI = 23;
    localparam int ST_SUP_LO = 18;
    localparam int ST_ALERT_B = 17;
    localparam int ST_RSVD_B = 16;
    localparam int ST_ERR_B = 15;
    localparam int ST_LEN_HI = 14;
    localparam int ST_LEN_LO = 10;
    localparam int ST_PER_HI = 9;
    localparam int ST_PER_LO = 0;
    // ==================================================
    // Trim field positions and reset values
    localparam int TR_SLICE_HI = 5;
    localparam int TR_SLICE_LO = 2;
    localparam int TR_UP_B = 1;
    localparam int TR_DN_B = 0;
    localparam logic [5:0] TRIM_LEG_RST = 6'h20;
    // Extended view reset: discriminator range 10, signal clock 10, legacy bits 20
    localparam logic [31:0] TRIM_EXT_RST = 32'h04800020;
    localparam logic [31:0] TRIM_LEG_MASK = 32'h0000003F;
    // Reserved extended bits 21 and 8-6 must stay zero
    localparam logic [31:0] TRIM_EXT_MASK = 32'hFFDFFE3F;
    // ==================================================
    // Register selector for the serial register port
    typedef enum logic [1:0] {
        RST_SEL_NONE = 2'h0,
        RST_SEL_STATUS = 2'h1,
        RST_SEL_TRIM = 2'h2
    } rst_sel_t;
endpackage

/* File: pkg/rst_trim_if.sv */
// Interface carrying trim write requests and the trim contents
`timescale 1ns/1ns
interface rst_trim_if;
    logic wr_en;
    logic [31:0] wr_data;
    logic ext_en;
    logic [31:0] trim;
    modport owner (input wr_en, input wr_data, input ext_en, output trim);
    modport user (output wr_en, output wr_data, output ext_en, input trim);
endinterface

/* File: tb/rst_host_model.sv */
// Companion controller model driving the register port
`timescale 1ns/1ns
module rst_host_model (
    input wire logic clk_i,
    output rst_pkg::rst_sel_t sel_o,
    output logic wr_o,
    output logic rd_o,
    output logic [31:0] wdata_o
);
    import rst_pkg::*;
    // One access held over one sampling edge, data line scrambled afterwards
    task automatic access(input rst_sel_t s, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        sel_o = s;
        wr_o = w;
        rd_o = !w;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        sel_o = RST_SEL_NONE;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = ~d;
    endtask
    // Idle port at time zero
    initial begin
        sel_o = RST_SEL_NONE;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 32'h0;
    end
endmodule

/* File: tb/rst_regs_monitor.sv */
// Assertion checker for the register bank ports
`timescale 1ns/1ns
module rst_regs_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rst_pkg::rst_sel_t sel_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic extended_feature_enable_i,
    input wire logic offset_measure_select_i,
    input wire logic [5:0] supply_adc_i,
    input wire logic [5:0] disc_adc_i,
    input wire logic alert_pin_raw_i,
    input wire logic discriminator_shift_up_o,
    input wire logic discriminator_shift_down_o,
    input wire logic [31:0] trim_ext_o
);
    import rst_pkg::*;
    logic up_r;
    logic st_q;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Flags a status read whose sources were sampled after reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_r <= 1'b0;
            st_q <= 1'b0;
        end else begin
            up_r <= 1'b1;
            st_q <= rd_i && sel_i == RST_SEL_STATUS && up_r;
        end
    end
    rd_answer_a: assert property (rd_i && sel_i == RST_SEL_STATUS |=> rvalid_o)
        else $error("read not answered");
    idle_zero_a: assert property (!rd_i |=> !rvalid_o && rdata_o == 32'h0)
        else $error("read data without read");
    alert_copy_a: assert property (st_q |-> rdata_o[17] == $past(alert_pin_raw_i, 2))
        else $error("alert bit wrong");
    meas_sel_a: assert property (st_q |-> rdata_o[23:18] ==
        ($past(offset_measure_select_i, 2) ? $past(disc_adc_i, 2) : $past(supply_adc_i, 2)))
        else $error("measurement field wrong");
    rsvd_zero_a: assert property (st_q |-> !rdata_o[31] && !rdata_o[16])
        else $error("reserved status bit set");
    shift_map_a: assert property ({discriminator_shift_up_o, discriminator_shift_down_o}
        == trim_ext_o[1:0]) else $error("shift outputs wrong");
    legacy_view_a: assert property (!extended_feature_enable_i [*3] |->
        trim_ext_o[31:6] == 26'h0) else $error("legacy view too wide");
    ext_rsvd_a: assert property (extended_feature_enable_i [*3] |->
        !trim_ext_o[21] && trim_ext_o[8:6] == 3'h0) else $error("reserved trim bit set");
endmodule
bind rst_regs rst_regs_monitor i_mon (.*);

/* File: tb/tb.sv */
// Self-checking bench for the status and trim register bank
`timescale 1ns/1ns
module tb;
    import rst_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ext = 1'b0;
    logic h_wr, h_rd, rvalid, up, dn;
    logic [3:0] slc;
    logic [31:0] h_wd, rdata, trim_ext, d, e;
    logic [37:0] src = '0;
    rst_sel_t h_sel;
    logic [31:0] exp_q[$];
    int miscompares = 0;
    int samples_checked = 0;
    rst_host_model i_host (.clk_i(clk_i), .sel_o(h_sel), .wr_o(h_wr), .rd_o(h_rd), .wdata_o(h_wd));
    rst_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .sel_i(h_sel), .wr_i(h_wr), .rd_i(h_rd),
        .wdata_i(h_wd), .rdata_o(rdata), .rvalid_o(rvalid), .extended_feature_enable_i(ext),
        .offset_measure_select_i(src[0]), .slicer_ref_internal_i(1'b1),
        .synth_lock_flag_i(src[37]), .measured_signal_level_i(src[36:31]),
        .supply_adc_i(src[30:25]), .disc_adc_i(src[24:19]), .alert_pin_raw_i(src[18]),
        .test_msg_mode_i(src[17]), .alert_msg_error_i(src[16]),
        .alert_payload_length_i(src[15:11]), .alert_bit_period_i(src[10:1]),
        .slicer_reference_trim_o(slc), .discriminator_shift_up_o(up),
        .discriminator_shift_down_o(dn), .trim_ext_o(trim_ext));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd_chk(input rst_sel_t s, input logic [31:0] x);
        exp_q.push_back(x);
        i_host.access(s, 1'b0, 32'h0);
    endtask
    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Clock of 40 ns period
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // Each read answer against the oldest noted value
    always @(negedge clk_i) begin
        if (rvalid === 1'b1) begin
            chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 32'hX, rdata);
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'hE522BE42));
        repeat (3) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd_chk(RST_SEL_TRIM, 32'h20);
        chk("trim out", 32'h20, 32'({slc, up, dn}));
        ext = 1'b1;
        rd_chk(RST_SEL_TRIM, TRIM_EXT_RST);
        ext = 1'b0;
        i_host.access(RST_SEL_TRIM, 1'b1, 32'hFFFFFFFF);
        rd_chk(RST_SEL_TRIM, TRIM_LEG_MASK);
        chk("trim out", 32'h3F, 32'({slc, up, dn}));
        ext = 1'b1;
        rd_chk(RST_SEL_TRIM, 32'h0480003F);
        for (int i = 0; i < 6; i++) begin
            d = $urandom();
            i_host.access(RST_SEL_TRIM, 1'b1, d);
            i_host.access(i[0] ? RST_SEL_NONE : rst_sel_t'(2'h3), 1'b1, ~d);
            rd_chk(RST_SEL_TRIM, d & TRIM_EXT_MASK);
            chk("trim ext", d & TRIM_EXT_MASK, trim_ext);
            chk("trim out", 32'(d[5:0]), 32'({slc, up, dn}));
        end
        for (int i = 0; i < 12; i++) begin
            src = 38'({$urandom(), $urandom()});
            e = {1'b0, src[37:31], src[0] ? src[24:19] : src[30:25], src[18], 1'b0,
                src[17] & src[16], src[15:1]};
            i_host.access(RST_SEL_STATUS, 1'b1, ~e);
            rd_chk(RST_SEL_STATUS, e);
        end
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk_i);
        if (exp_q.size() > 0) begin
            miscompares++;
            $display("ERROR pending reads expected 0 seen %0d", exp_q.size());
        end
        test_done();
    end
endmodule
